// >>> core/usi_pkg.sv
// Shared constants and types for the universal serial shift unit
package usi_pkg;
  localparam int SHIFT_W = 8;
  localparam int CNT_W = 4;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int SCK_DIVIDER_MIN = 4;

  typedef enum logic [1:0] {
    wm_off,
    wm_three,
    wm_two,
    wm_two_hold
  } wire_mode_t;

  typedef enum logic [1:0] {
    src_none,
    src_software,
    src_timer,
    src_external
  } clk_src_t;

  typedef struct packed {
    wire_mode_t wire_mode;
    clk_src_t clk_src;
    logic ext_clock_edge_select;
    logic overflow_int_en;
    logic start_int_en;
    logic clock_pin_dir;
    logic data_pin_dir;
  } serial_control_reg_t;

  typedef struct packed {
    logic data_wr;
    logic [7:0] data;
    logic cnt_wr;
    logic [3:0] cnt;
    logic overflow_clr;
    logic start_clr;
    logic clock_toggle_strobe;
    logic software_clock_strobe;
  } cpu_strobe_t;

  typedef struct packed {
    logic [7:0] serial_shift_reg;
    logic [3:0] count;
    logic counter_overflow_flag;
    logic start_flag;
  } serial_status_reg_t;
endpackage

// >>> core/universal_serial_shift_unit.sv
// Universal serial shift unit: shift register, edge counter, clock select and pin logic
// Function
// RULE_01 - Eight-bit shift register, CPU readable and writable, no receive buffer.
// RULE_02 - Shift register MSB drives one of two output pins per wire mode.
// RULE_03 - Transparent latch delays output change to the edge opposite sampling.
// RULE_04 - Serial input always comes from the data-input pin.
// RULE_05 - Four-bit CPU-accessible counter raises an interrupt on overflow.
// RULE_06 - Shift register and counter advance on the same clock event.
// RULE_07 - With external clock the counter counts both edges.
// RULE_08 - Shift clock from clock pin, timer compare match or software strobe.
// RULE_09 - Two-wire mode flags start condition and may request an interrupt.
// RULE_10 - Clock pin held low after start condition or counter overflow.
// RULE_11 - Three-wire mode follows SPI modes 0 and 1, no slave select.
// RULE_12 - Writing the toggle strobe toggles the serial clock pin.
// RULE_13 - Edge select zero: sample on rising, shift output on falling.
// RULE_14 - Edge select one: sample on falling, change output on rising.
// RULE_15 - Both parties set first bit half a clock before sampling edge.
// RULE_16 - Before each byte, counter cleared and outgoing byte loaded.
// RULE_17 - Master issues eight full clock pulses per byte.
// RULE_18 - Sixteen counted edges overflow the counter and set the flag.
// RULE_19 - Received byte read out before next transfer starts.
// RULE_20 - Enabled overflow interrupt can wake the processor from idle.
// RULE_21 - Shift clock no faster than a quarter of system clock.
// RULE_22 - Overflow flag sticky until written one; counter wraps fifteen to zero.
// RULE_23 - Clock pin activity synchronised to system clock before edge detection.
`timescale 1ns/1ps
module universal_serial_shift_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic timer0_compare_match,
  input usi_pkg::serial_control_reg_t serial_control_reg,
  input usi_pkg::cpu_strobe_t cpu_strobe,
  output usi_pkg::serial_status_reg_t serial_status_reg,
  output logic data_out,
  output logic data_out_oe_n,
  output logic sda_oe_n,
  output logic clock_out,
  output logic clock_oe_n,
  output logic irq_overflow,
  output logic irq_start
);
  // Link domain: runs on the serial clock pin, captures input at each edge
  logic rise_tgl;
  logic fall_tgl;
  logic rise_bit;
  logic fall_bit;

  always_ff @(posedge serial_clock_pin or negedge rst_n) begin
    if (!rst_n) begin
      rise_tgl <= 1'b0;
      rise_bit <= 1'b0;
    end else begin
      rise_tgl <= ~rise_tgl;
      rise_bit <= serial_in_pin; // see RULE_04
    end
  end

  always_ff @(negedge serial_clock_pin or negedge rst_n) begin
    if (!rst_n) begin
      fall_tgl <= 1'b0;
      fall_bit <= 1'b0;
    end else begin
      fall_tgl <= ~fall_tgl;
      fall_bit <= serial_in_pin; // see RULE_04
    end
  end

  // Crossing: bit order {di pin, fall bit, rise bit, fall toggle, rise toggle}
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [1:0] tgl_d1;
  logic [1:0] tgl_d2;
  logic di_d;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      tgl_d1 <= 2'h0;
      tgl_d2 <= 2'h0;
      di_d <= 1'b0;
    end else begin
      sync_a <= {serial_in_pin, fall_bit, rise_bit, fall_tgl, rise_tgl}; // see RULE_23
      sync_b <= sync_a;
      tgl_d1 <= sync_b[1:0];
      tgl_d2 <= tgl_d1;
      di_d <= sync_b[4];
    end
  end

  // Events taken one stage late so the captured bit is already settled
  wire rise_ev = tgl_d1[0] ^ tgl_d2[0]; // see RULE_23
  wire fall_ev = tgl_d1[1] ^ tgl_d2[1];
  // Pin level rebuilt from edge parity; assumes the pin is low at reset
  wire scl_level = tgl_d1[0] ^ tgl_d1[1];
  wire di_s = sync_b[4];

  wire cs0 = serial_control_reg.ext_clock_edge_select;
  wire ext_sel = serial_control_reg.clk_src == usi_pkg::src_external;
  wire sw_sel = serial_control_reg.clk_src == usi_pkg::src_software;
  wire tmr_sel = serial_control_reg.clk_src == usi_pkg::src_timer;
  wire active = serial_control_reg.wire_mode != usi_pkg::wm_off;
  wire three_wire = serial_control_reg.wire_mode == usi_pkg::wm_three;
  wire two_wire = serial_control_reg.wire_mode == usi_pkg::wm_two
    || serial_control_reg.wire_mode == usi_pkg::wm_two_hold;

  // Clock source select and edge polarity
  wire ext_sample_ev = cs0 ? fall_ev : rise_ev; // see RULE_13 see RULE_14
  wire int_ev = (sw_sel & cpu_strobe.software_clock_strobe)
    | (tmr_sel & timer0_compare_match); // see RULE_08
  wire sample_ev = ext_sel ? ext_sample_ev : int_ev;
  wire count_ev = ext_sel ? (rise_ev | fall_ev) : int_ev; // see RULE_07
  wire sample_bit = ext_sel ? (cs0 ? sync_b[3] : sync_b[2]) : di_s;
  wire shift_ev = active & sample_ev; // see RULE_06
  wire count_step = active & count_ev; // see RULE_06

  logic [7:0] shift;
  logic [3:0] count;
  logic ovf_flag;
  logic start_flag;
  assign shift = serial_status_reg.serial_shift_reg;
  assign count = serial_status_reg.count;
  assign ovf_flag = serial_status_reg.counter_overflow_flag;
  assign start_flag = serial_status_reg.start_flag;

  wire overflow_ev = count_step & (count == usi_pkg::CNT_MAX); // see RULE_18
  wire start_ev = two_wire & scl_level & di_d & ~di_s; // see RULE_09

  // CPU writes to the shift register and counter take priority over a clock event in the same cycle
  wire [7:0] next_shift = cpu_strobe.data_wr ? cpu_strobe.data
    : shift_ev ? {shift[6:0], sample_bit} : shift; // see RULE_01
  wire [3:0] next_count = cpu_strobe.cnt_wr ? cpu_strobe.cnt
    : count_step ? count + usi_pkg::CNT_STEP : count; // see RULE_05 see RULE_22
  // Hardware set wins over a software clear
  wire next_ovf = overflow_ev | (ovf_flag & ~cpu_strobe.overflow_clr); // see RULE_22
  wire next_start = start_ev | (start_flag & ~cpu_strobe.start_clr); // see RULE_09

  wire hold_low = two_wire & (start_flag
    | (serial_control_reg.wire_mode == usi_pkg::wm_two_hold & ovf_flag)); // see RULE_10

  // Latch is open during the idle phase of the sampling edge
  wire latch_open = ~ext_sel | (scl_level == cs0); // see RULE_03
  wire next_data_out = latch_open ? shift[7] : data_out;

  logic scl_port;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_status_reg <= '{usi_pkg::SHIFT_RESET, usi_pkg::CNT_RESET, 1'b0, 1'b0};
    end else begin
      serial_status_reg <= '{next_shift, next_count, next_ovf, next_start};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 1'b0;
      scl_port <= 1'b0;
    end else begin
      data_out <= next_data_out; // see RULE_03
      scl_port <= scl_port ^ cpu_strobe.clock_toggle_strobe; // see RULE_12
    end
  end

  // Pin drivers; slave select is left to software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      clock_out <= 1'b0;
      clock_oe_n <= 1'b1;
    end else begin
      data_out_oe_n <= ~(three_wire & serial_control_reg.data_pin_dir); // see RULE_02 see RULE_11
      sda_oe_n <= ~(two_wire & serial_control_reg.data_pin_dir & ~next_data_out); // see RULE_02
      clock_out <= scl_port & ~hold_low; // see RULE_10
      clock_oe_n <= ~(serial_control_reg.clock_pin_dir | hold_low);
    end
  end

  // Overflow request also serves as the idle wake-up source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_overflow <= 1'b0;
      irq_start <= 1'b0;
    end else begin
      irq_overflow <= next_ovf & serial_control_reg.overflow_int_en; // see RULE_05 see RULE_20
      irq_start <= next_start & serial_control_reg.start_int_en; // see RULE_09
    end
  end

  AST_OVF_SET: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_18
    overflow_ev |=> ovf_flag)
    else $error("overflow event did not set the flag");

  AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_22
    overflow_ev && !cpu_strobe.cnt_wr |=> count == usi_pkg::CNT_RESET)
    else $error("counter did not wrap to zero");

  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_22
    ovf_flag && !cpu_strobe.overflow_clr |=> ovf_flag)
    else $error("overflow flag dropped without a clear");

  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_01
    shift_ev && !cpu_strobe.data_wr |=> shift == {$past(shift[6:0]), $past(sample_bit)})
    else $error("shift register did not take the input bit");

  AST_BOTH_EDGES: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_07
    active && ext_sel && (rise_ev || fall_ev) && !cpu_strobe.cnt_wr
    |=> count == $past(count) + usi_pkg::CNT_STEP)
    else $error("external edge not counted");

  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_03
    !latch_open |=> $stable(data_out))
    else $error("output changed while latch closed");

  AST_MODE0_EDGE: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_13
    ext_sel && !cs0 && fall_ev && !rise_ev && !cpu_strobe.data_wr |=> $stable(shift))
    else $error("mode 0 shifted on a falling edge");

  AST_MODE1_EDGE: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_14
    ext_sel && cs0 && rise_ev && !fall_ev && !cpu_strobe.data_wr |=> $stable(shift))
    else $error("mode 1 shifted on a rising edge");

  AST_SAME_EVENT: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_06
    shift_ev |-> count_step)
    else $error("shift without counter step");

  AST_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_12
    cpu_strobe.clock_toggle_strobe && !hold_low ##1 !hold_low |=> clock_out != $past(clock_out, 2))
    else $error("toggle strobe did not toggle the clock pin");

  AST_HOLD_LOW: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_10
    hold_low |=> !clock_out && !clock_oe_n)
    else $error("clock pin not held low");

  AST_START: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_09
    start_ev ##1 serial_control_reg.start_int_en |-> start_flag && irq_start)
    else $error("start condition not flagged");

  AST_IRQ_OVF: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_20
    overflow_ev && serial_control_reg.overflow_int_en |=> irq_overflow)
    else $error("overflow request missing");

  AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_23
    rise_ev |-> $past(sync_b[0], 2) != $past(sync_b[0], 1) || tgl_d1[0] != tgl_d2[0])
    else $error("edge event without synchronised change");
endmodule

// >>> testbench/spi_master_model.sv
// Serial master model that clocks the link and exchanges one byte at a time
`timescale 1ns/1ps
module spi_master_model (
  output logic sck,
  output logic si,
  input wire logic so
);
  logic base_clk;
  initial begin
    base_clk = 1'b0;
    sck = 1'b0;
    si = 1'b0;
    #13;
    forever #32 base_clk = ~base_clk;
  end
  // Long half period so each edge has settled inside the unit before the next
  task automatic half();
    repeat (8) @(posedge base_clk);
  endtask
  task automatic set_lines(input logic c, input logic d);
    half();
    sck = c;
    si = d;
  endtask
  // Eight full pulses, first bit set up half a period ahead of its sampling edge
  task automatic xfer(input logic mode, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (!mode)
        si = tx[i];
      half();
      if (!mode)
        rx = {rx[6:0], so};
      sck = 1'b1;
      if (mode)
        si = tx[i];
      half();
      if (mode)
        rx = {rx[6:0], so};
      sck = 1'b0;
    end
    half();
    si = ~si;
  endtask
endmodule

// >>> testbench/test_usi_three_wire_serial.sv
// Self-checking bench for the serial shift unit against a master model
`timescale 1ns/1ps
module test_usi_three_wire_serial;
  logic clk, rst_n, tmr, m_sck, si, dout, dout_oe_n, ck_out, ck_oe_n, irq_ov, irq_st;
  logic [7:0] rx;
  usi_pkg::serial_control_reg_t ctl;
  usi_pkg::cpu_strobe_t stb;
  usi_pkg::serial_status_reg_t st;
  int err_count = 0;
  int total_checks = 0;
  // Pin level resolved between the unit's driver and the master
  wire logic pin_sck = ck_oe_n ? m_sck : ck_out;
  universal_serial_shift_unit dut_u (.clk(clk), .rst_n(rst_n), .serial_clock_pin(pin_sck),
    .serial_in_pin(si), .timer0_compare_match(tmr), .serial_control_reg(ctl),
    .cpu_strobe(stb), .serial_status_reg(st), .data_out(dout), .data_out_oe_n(dout_oe_n),
    .sda_oe_n(), .clock_out(ck_out), .clock_oe_n(ck_oe_n), .irq_overflow(irq_ov),
    .irq_start(irq_st));
  spi_master_model mst_u (.sck(m_sck), .si(si), .so(dout));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cfg(input usi_pkg::wire_mode_t w, input usi_pkg::clk_src_t s, input logic e,
                     input logic d);
    @(negedge clk);
    // Master model owns the clock pin whenever the pin is the shift clock source
    ctl = '{w, s, e, 1'b1, 1'b1, d & (s != usi_pkg::src_external), d};
  endtask
  task automatic prep(input logic [7:0] d);
    @(negedge clk);
    stb.data_wr = 1'b1;
    stb.data = d;
    stb.cnt_wr = 1'b1;
    stb.cnt = 4'h0;
    stb.overflow_clr = 1'b1;
    stb.start_clr = 1'b1;
    @(negedge clk);
    stb = '0;
  endtask
  task automatic ev(input usi_pkg::clk_src_t s, input int n);
    repeat (n) begin
      @(negedge clk);
      if (s == usi_pkg::src_timer)
        tmr = 1'b1;
      else
        stb.software_clock_strobe = 1'b1;
      @(negedge clk);
      tmr = 1'b0;
      stb = '0;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic t_ext(input logic m, input logic [7:0] d, input logic [7:0] mtx);
    cfg(usi_pkg::wm_three, usi_pkg::src_external, m, 1'b0);
    prep(d);
    chk(dout_oe_n, 1'b1);
    cfg(usi_pkg::wm_three, usi_pkg::src_external, m, 1'b1);
    mst_u.xfer(m, mtx, rx);
    repeat (8) @(negedge clk);
    chk(dout_oe_n, 1'b0);
    chk(rx, d);
    chk(st.serial_shift_reg, mtx);
    chk({st.count, irq_ov, st.counter_overflow_flag}, 8'h03);
  endtask
  task automatic t_int(input usi_pkg::clk_src_t s, input logic d);
    cfg(usi_pkg::wm_three, s, 1'b0, 1'b0);
    mst_u.set_lines(1'b0, d);
    prep(8'h5a);
    ev(s, 8);
    chk(st.serial_shift_reg, {8{d}});
    chk({st.count, st.counter_overflow_flag}, 8'h10);
    ev(s, 8);
    chk({st.count, irq_ov, st.counter_overflow_flag}, 8'h03);
    cfg(usi_pkg::wm_off, s, 1'b0, 1'b0);
    ev(s, 3);
    chk({st.count, st.counter_overflow_flag}, 8'h01);
    @(negedge clk);
    stb.overflow_clr = 1'b1;
    @(negedge clk);
    stb = '0;
    @(negedge clk);
    chk({irq_ov, st.counter_overflow_flag}, 8'h00);
  endtask
  task automatic t_toggle();
    cfg(usi_pkg::wm_three, usi_pkg::src_software, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      stb.clock_toggle_strobe = 1'b1;
      @(negedge clk);
      stb = '0;
      repeat (2) @(negedge clk);
      chk({ck_out, ck_oe_n}, {7'h00, i == 0} << 1);
    end
  endtask
  task automatic t_start();
    cfg(usi_pkg::wm_two, usi_pkg::src_external, 1'b0, 1'b1);
    mst_u.set_lines(1'b1, 1'b1);
    mst_u.set_lines(1'b1, 1'b0);
    repeat (8) @(negedge clk);
    chk({st.start_flag, irq_st, ck_out, ck_oe_n}, 8'h0c);
  endtask
  initial begin
    rst_n = 1'b0;
    tmr = 1'b0;
    ctl = '0;
    stb = '0;
    repeat (12) @(negedge clk);
    chk(st.serial_shift_reg, 8'h00);
    chk({st.count, dout, ck_oe_n, irq_ov, st.counter_overflow_flag}, 8'h04);
    rst_n = 1'b1;
    t_ext(1'b0, 8'ha5, 8'h3c);
    t_ext(1'b1, 8'h69, 8'hc3);
    t_int(usi_pkg::src_software, 1'b1);
    t_int(usi_pkg::src_timer, 1'b0);
    t_toggle();
    t_start();
    tally_and_finish();
  end
  initial begin
    #300000;
    err_count++;
    tally_and_finish();
  end
endmodule
